// ==== hdl/pcr_pkg.sv ====
/*
  Package for the PWM channel register file: register word offsets,
  field positions, reset values and sync, event and force codes.
  Assumes a 32-bit peripheral bus whose address counts 16-bit words.
*/
`default_nettype none
package pcr_pkg;
  localparam int unsigned REG_COUNT = 33;
  localparam int unsigned ADDR_W    = 6;

  // Word offsets, 16-bit units
  localparam logic [5:0] OFF_TB_CTL      = 6'h00;
  localparam logic [5:0] OFF_TB_STS      = 6'h01;
  localparam logic [5:0] OFF_FINE_PHASE  = 6'h02;
  localparam logic [5:0] OFF_TB_PHASE    = 6'h03;
  localparam logic [5:0] OFF_TB_COUNTER  = 6'h04;
  localparam logic [5:0] OFF_TB_PERIOD   = 6'h05;
  localparam logic [5:0] OFF_RSV_A       = 6'h06;
  localparam logic [5:0] OFF_CMP_CTL     = 6'h07;
  localparam logic [5:0] OFF_FINE_COMPARE_A_VALUE   = 6'h08;
  localparam logic [5:0] OFF_COMPARE_A_VALUE        = 6'h09;
  localparam logic [5:0] OFF_CMPB        = 6'h0a;
  localparam logic [5:0] OFF_AQ_A        = 6'h0b;
  localparam logic [5:0] OFF_AQ_B        = 6'h0c;
  localparam logic [5:0] OFF_ONE_FORCE   = 6'h0d;
  localparam logic [5:0] OFF_CONT_FORCE  = 6'h0e;
  localparam logic [5:0] OFF_DB_CTL      = 6'h0f;
  localparam logic [5:0] OFF_DB_RISE     = 6'h10;
  localparam logic [5:0] OFF_DB_FALL     = 6'h11;
  localparam logic [5:0] OFF_FAULT_SEL   = 6'h12;
  localparam logic [5:0] OFF_RSV_B       = 6'h13;
  localparam logic [5:0] OFF_FAULT_CTL   = 6'h14;
  localparam logic [5:0] OFF_FAULT_INT   = 6'h15;
  localparam logic [5:0] OFF_FAULT_FLAGS = 6'h16;
  localparam logic [5:0] OFF_FAULT_CLR   = 6'h17;
  localparam logic [5:0] OFF_FAULT_FRC   = 6'h18;
  localparam logic [5:0] OFF_ET_SEL      = 6'h19;
  localparam logic [5:0] OFF_ET_PS       = 6'h1a;
  localparam logic [5:0] OFF_ET_FLAGS    = 6'h1b;
  localparam logic [5:0] OFF_ET_CLR      = 6'h1c;
  localparam logic [5:0] OFF_ET_FRC      = 6'h1d;
  localparam logic [5:0] OFF_CHOP_CTL    = 6'h1e;
  localparam logic [5:0] OFF_RSV_C       = 6'h1f;
  localparam logic [5:0] OFF_FINE_CFG    = 6'h20;

  // Field positions
  localparam int unsigned TB_CTL_SYNC_USE  = 2;
  localparam int unsigned TB_CTL_SYNC_SEL  = 4;
  localparam int unsigned TB_STS_SYNC_SEEN = 1;
  localparam int unsigned FAULT_CTL_A_HIGH = 0;
  localparam int unsigned FAULT_CTL_B_HIGH = 2;
  localparam int unsigned FAULT_FLAG_TRIP  = 0;
  localparam int unsigned ET_SEL_A_POS     = 8;
  localparam int unsigned ET_SEL_A_EN      = 11;
  localparam int unsigned ET_SEL_B_POS     = 12;
  localparam int unsigned ET_SEL_B_EN      = 15;
  localparam int unsigned ET_FLAG_A        = 2;
  localparam int unsigned ET_FLAG_B        = 3;
  localparam int unsigned FORCE_A_POS      = 0;
  localparam int unsigned FORCE_B_POS      = 2;

  // Sync output sources
  localparam logic [1:0] SYNC_SRC_INPUT = 2'h0;
  localparam logic [1:0] SYNC_SRC_ZERO  = 2'h1;
  localparam logic [1:0] SYNC_SRC_CMPB  = 2'h2;

  // Converter start event codes
  localparam logic [2:0] EV_ZERO   = 3'h1;
  localparam logic [2:0] EV_PERIOD = 3'h2;
  localparam logic [2:0] EV_COMPARE_A_VALUE   = 3'h4;
  localparam logic [2:0] EV_CMPB   = 3'h6;

  // Continuous force codes
  localparam logic [1:0] FORCE_LOW  = 2'h1;
  localparam logic [1:0] FORCE_HIGH = 2'h2;

  localparam logic [15:0] REG_RESET = 16'h0000;
endpackage : pcr_pkg
`default_nettype wire

// ==== hdl/pcr_regs.sv ====
/*
  Register file and signal boundary of one PWM channel, with a minimal
  time base, compare, trip and event path so the registers steer real
  outputs. Assumes a CPU on a 32-bit peripheral bus addressing 16-bit
  words; all inputs are synchronous to mclk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_regs #(
  parameter bit HAS_FINE = 1'b1,
  parameter bit IS_FIRST = 1'b0
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // Peripheral bus
  input  wire logic [5:0]  bus_addr_i,
  input  wire logic [31:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_wr32_i,
  input  wire logic        bus_rd_i,
  output logic      [31:0] bus_rdata_o,
  input  wire logic        protected_write_unlock_i,
  // Faults and sync chain
  input  wire logic [5:0]  fault_in_i,
  input  wire logic        chain_sync_in_i,
  output logic             chain_sync_out_o,
  output logic             capture_sync_in_o,
  // Outputs
  output logic             pwm_out_a_o,
  output logic             pwm_out_b_o,
  output logic             conv_start_a_o,
  output logic             conv_start_b_o
);

  if (pcr_pkg::ADDR_W != 6) begin : g_chk
    $error("pcr_regs needs a 6-bit word address");
  end

  // Address classes
  function automatic logic is_reserved(input logic [5:0] a);
    logic fine;
    fine = (a == pcr_pkg::OFF_FINE_PHASE) || (a == pcr_pkg::OFF_FINE_COMPARE_A_VALUE) ||
           (a == pcr_pkg::OFF_FINE_CFG);
    return (a == pcr_pkg::OFF_RSV_A) || (a == pcr_pkg::OFF_RSV_B) ||
           (a == pcr_pkg::OFF_RSV_C) || (a > pcr_pkg::OFF_FINE_CFG) ||
           (fine && !HAS_FINE);
  endfunction : is_reserved

  function automatic logic is_protected(input logic [5:0] a);
    return ((a >= pcr_pkg::OFF_FAULT_CTL) && (a <= pcr_pkg::OFF_FAULT_FRC)) ||
           (a == pcr_pkg::OFF_FINE_CFG);
  endfunction : is_protected

  // Write strobe for one word; a 32-bit write covers an even word and the next
  function automatic logic wr_hit(input logic [5:0] a);
    logic hit;
    hit = bus_wr_i && ((!bus_wr32_i && bus_addr_i == a) ||
          (bus_wr32_i && !bus_addr_i[0] &&
           (bus_addr_i == a || bus_addr_i == a - 6'h01)));
    return hit && !is_reserved(a) &&
           (!is_protected(a) || protected_write_unlock_i);
  endfunction : wr_hit

  function automatic logic [15:0] wr_data(input logic [5:0] a);
    return (bus_wr32_i && a[0]) ? bus_wdata_i[31:16] : bus_wdata_i[15:0];
  endfunction : wr_data

  function automatic logic ev_pick(input logic [2:0] sel, input logic zero,
                                   input logic prd, input logic ca, input logic cb);
    case (sel)
      pcr_pkg::EV_ZERO:   return zero;
      pcr_pkg::EV_PERIOD: return prd;
      pcr_pkg::EV_COMPARE_A_VALUE:   return ca;
      pcr_pkg::EV_CMPB:   return cb;
      default:            return 1'b0;
    endcase
  endfunction : ev_pick

  // Stored registers; shadowed ones hold the software side here
  logic [15:0] regs      [0:pcr_pkg::REG_COUNT-1];
  logic [15:0] next_regs [0:pcr_pkg::REG_COUNT-1];

  always_comb begin
    for (int i = 0; i < pcr_pkg::REG_COUNT; i++) begin
      next_regs[i] = regs[i];
      if (wr_hit(6'(i))) begin
        next_regs[i] = wr_data(6'(i));
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < pcr_pkg::REG_COUNT; i++) begin
        regs[i] <= pcr_pkg::REG_RESET;
      end
    end else begin
      regs <= next_regs;
    end
  end

  // Active copies of shadowed registers, loaded when the counter wraps
  logic [15:0] period_act;
  logic [15:0] compare_a_value_act;
  logic [15:0] cmpb_act;
  logic [15:0] force_act;
  logic [15:0] next_period_act;
  logic [15:0] next_compare_a_value_act;
  logic [15:0] next_cmpb_act;
  logic [15:0] next_force_act;
  logic [15:0] counter;
  logic [15:0] next_counter;
  logic        sync_seen;
  logic        next_sync_seen;

  logic ctr_zero;
  logic ctr_period;
  logic ctr_compare_a_value;
  logic ctr_cmpb;
  logic sync_take;

  assign ctr_zero   = (counter == 16'h0000);
  assign ctr_period = (counter >= period_act);
  assign ctr_compare_a_value   = (counter == compare_a_value_act);
  assign ctr_cmpb   = (counter == cmpb_act);
  assign sync_take  = chain_sync_in_i &&
                      regs[pcr_pkg::OFF_TB_CTL][pcr_pkg::TB_CTL_SYNC_USE];

  always_comb begin
    next_period_act = period_act;
    next_compare_a_value_act   = compare_a_value_act;
    next_cmpb_act   = cmpb_act;
    next_force_act  = force_act;
    if (ctr_period) begin
      next_period_act = regs[pcr_pkg::OFF_TB_PERIOD];
      next_compare_a_value_act   = regs[pcr_pkg::OFF_COMPARE_A_VALUE];
      next_cmpb_act   = regs[pcr_pkg::OFF_CMPB];
      next_force_act  = regs[pcr_pkg::OFF_CONT_FORCE];
    end
    if (wr_hit(pcr_pkg::OFF_TB_COUNTER)) begin
      next_counter = wr_data(pcr_pkg::OFF_TB_COUNTER);
    end else if (sync_take) begin
      next_counter = regs[pcr_pkg::OFF_TB_PHASE];
    end else if (ctr_period) begin
      next_counter = 16'h0000;
    end else begin
      next_counter = counter + 16'h0001;
    end
    // Sync-seen status: hardware set wins over a write-one clear
    next_sync_seen = sync_seen;
    if (wr_hit(pcr_pkg::OFF_TB_STS) &&
        wr_data(pcr_pkg::OFF_TB_STS)[pcr_pkg::TB_STS_SYNC_SEEN]) begin
      next_sync_seen = 1'b0;
    end
    if (chain_sync_in_i) begin
      next_sync_seen = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      period_act <= pcr_pkg::REG_RESET;
      compare_a_value_act   <= pcr_pkg::REG_RESET;
      cmpb_act   <= pcr_pkg::REG_RESET;
      force_act  <= pcr_pkg::REG_RESET;
      counter    <= pcr_pkg::REG_RESET;
      sync_seen  <= 1'b0;
    end else begin
      period_act <= next_period_act;
      compare_a_value_act   <= next_compare_a_value_act;
      cmpb_act   <= next_cmpb_act;
      force_act  <= next_force_act;
      counter    <= next_counter;
      sync_seen  <= next_sync_seen;
    end
  end

  // Trip latch and event flags
  logic       tripped;
  logic       next_tripped;
  logic [1:0] et_flags;
  logic [1:0] next_et_flags;
  logic       fault_hit;
  logic       soc_a;
  logic       soc_b;
  logic [15:0] et_sel;

  assign et_sel    = regs[pcr_pkg::OFF_ET_SEL];
  assign fault_hit = |(fault_in_i & regs[pcr_pkg::OFF_FAULT_SEL][5:0]);

  always_comb begin
    soc_a = et_sel[pcr_pkg::ET_SEL_A_EN] &&
            ev_pick(et_sel[pcr_pkg::ET_SEL_A_POS +: 3], ctr_zero, ctr_period,
                    ctr_compare_a_value, ctr_cmpb);
    soc_b = et_sel[pcr_pkg::ET_SEL_B_EN] &&
            ev_pick(et_sel[pcr_pkg::ET_SEL_B_POS +: 3], ctr_zero, ctr_period,
                    ctr_compare_a_value, ctr_cmpb);
    if (wr_hit(pcr_pkg::OFF_ET_FRC)) begin
      soc_a = soc_a || wr_data(pcr_pkg::OFF_ET_FRC)[pcr_pkg::ET_FLAG_A];
      soc_b = soc_b || wr_data(pcr_pkg::OFF_ET_FRC)[pcr_pkg::ET_FLAG_B];
    end
    next_tripped = tripped;
    if (wr_hit(pcr_pkg::OFF_FAULT_CLR) &&
        wr_data(pcr_pkg::OFF_FAULT_CLR)[pcr_pkg::FAULT_FLAG_TRIP]) begin
      next_tripped = 1'b0;
    end
    if (fault_hit || (wr_hit(pcr_pkg::OFF_FAULT_FRC) &&
        wr_data(pcr_pkg::OFF_FAULT_FRC)[pcr_pkg::FAULT_FLAG_TRIP])) begin
      next_tripped = 1'b1;
    end
    next_et_flags = et_flags;
    if (wr_hit(pcr_pkg::OFF_ET_CLR)) begin
      next_et_flags = et_flags & ~{wr_data(pcr_pkg::OFF_ET_CLR)[pcr_pkg::ET_FLAG_B],
                                   wr_data(pcr_pkg::OFF_ET_CLR)[pcr_pkg::ET_FLAG_A]};
    end
    next_et_flags = next_et_flags | {soc_b, soc_a};
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tripped  <= 1'b0;
      et_flags <= 2'h0;
    end else begin
      tripped  <= next_tripped;
      et_flags <= next_et_flags;
    end
  end

  // Output stage
  logic       next_pwm_a;
  logic       next_pwm_b;
  logic       next_sync_out;
  logic [1:0] force_a;
  logic [1:0] force_b;
  logic [15:0] fault_ctl;

  assign force_a   = force_act[pcr_pkg::FORCE_A_POS +: 2];
  assign force_b   = force_act[pcr_pkg::FORCE_B_POS +: 2];
  assign fault_ctl = regs[pcr_pkg::OFF_FAULT_CTL];

  always_comb begin
    next_pwm_a = (counter < compare_a_value_act);
    next_pwm_b = (counter < cmpb_act);
    if (force_a == pcr_pkg::FORCE_LOW) begin
      next_pwm_a = 1'b0;
    end else if (force_a == pcr_pkg::FORCE_HIGH) begin
      next_pwm_a = 1'b1;
    end
    if (force_b == pcr_pkg::FORCE_LOW) begin
      next_pwm_b = 1'b0;
    end else if (force_b == pcr_pkg::FORCE_HIGH) begin
      next_pwm_b = 1'b1;
    end
    if (tripped) begin
      next_pwm_a = fault_ctl[pcr_pkg::FAULT_CTL_A_HIGH];
      next_pwm_b = fault_ctl[pcr_pkg::FAULT_CTL_B_HIGH];
    end
    case (regs[pcr_pkg::OFF_TB_CTL][pcr_pkg::TB_CTL_SYNC_SEL +: 2])
      pcr_pkg::SYNC_SRC_INPUT: next_sync_out = chain_sync_in_i;
      pcr_pkg::SYNC_SRC_ZERO:  next_sync_out = ctr_zero;
      pcr_pkg::SYNC_SRC_CMPB:  next_sync_out = ctr_cmpb;
      default:                 next_sync_out = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwm_out_a_o       <= 1'b0;
      pwm_out_b_o       <= 1'b0;
      chain_sync_out_o  <= 1'b0;
      capture_sync_in_o <= 1'b0;
      conv_start_a_o    <= 1'b0;
      conv_start_b_o    <= 1'b0;
    end else begin
      pwm_out_a_o       <= next_pwm_a;
      pwm_out_b_o       <= next_pwm_b;
      chain_sync_out_o  <= next_sync_out;
      capture_sync_in_o <= IS_FIRST && next_sync_out;
      conv_start_a_o    <= soc_a;
      conv_start_b_o    <= soc_b;
    end
  end

  // Read path
  function automatic logic [15:0] rd16(input logic [5:0] a);
    if (is_reserved(a)) begin
      return 16'h0000;
    end
    case (a)
      pcr_pkg::OFF_TB_STS:      return 16'(sync_seen) << pcr_pkg::TB_STS_SYNC_SEEN;
      pcr_pkg::OFF_TB_COUNTER:  return counter;
      pcr_pkg::OFF_FAULT_FLAGS: return 16'(tripped) << pcr_pkg::FAULT_FLAG_TRIP;
      pcr_pkg::OFF_ET_FLAGS:    return {12'h000, et_flags, 2'h0};
      pcr_pkg::OFF_FAULT_CLR,
      pcr_pkg::OFF_FAULT_FRC,
      pcr_pkg::OFF_ET_CLR,
      pcr_pkg::OFF_ET_FRC:      return 16'h0000;
      default:                  return regs[a];
    endcase
  endfunction : rd16

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = bus_rdata_o;
    if (bus_rd_i) begin
      next_rdata = {rd16(bus_addr_i + 6'h01), rd16(bus_addr_i)};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bus_rdata_o <= 32'h0000_0000;
    end else begin
      bus_rdata_o <= next_rdata;
    end
  end

endmodule : pcr_regs
`default_nettype wire

// ==== verif/pcr_cpu.sv ====
/*
  CPU model on the peripheral bus: one access per cycle, launched at
  falling edges. Assumes the register file samples on rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_cpu (
  input  wire logic        mclk_i,
  input  wire logic [31:0] rdata_i,
  output var  logic [5:0]  addr_o,
  output var  logic [31:0] wdata_o,
  output var  logic        wr_o,
  output var  logic        wr32_o,
  output var  logic        rd_o,
  output var  logic        unlock_o
);
  initial begin
    unlock_o = 1'b0;
    cyc(1'b0, 1'b0, 1'b0, 6'h00, 32'h0000_0000);
  end
  // Drives one cycle; strobes stand over exactly one rising edge
  task automatic cyc(input logic w, input logic w32, input logic r, input logic [5:0] a,
                     input logic [31:0] d);
    wr_o = w;
    wr32_o = w32;
    rd_o = r;
    addr_o = a;
    wdata_o = d;
    @(negedge mclk_i);
  endtask : cyc
  task automatic idle();
    cyc(1'b0, 1'b0, 1'b0, 6'h3f, 32'hffff_ffff);
  endtask : idle
  task automatic wr(input logic [5:0] a, input logic w32, input logic [31:0] d);
    cyc(1'b1, w32, 1'b0, a, d);
    idle();
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    cyc(1'b0, 1'b0, 1'b1, a, 32'h0000_0000);
    idle();
    idle();
    d = rdata_i;
  endtask : rd
  task automatic lock(input logic u);
    unlock_o = u;
  endtask : lock
endmodule : pcr_cpu
`default_nettype wire

// ==== verif/pcr_regs_sva.sv ====
/*
  Checker for pcr_regs: bus read, write and sync relations at its ports.
  Assumes the single mclk_i domain and active-low reset_n_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_chk #(
  parameter bit HAS_FINE = 1'b1,
  parameter bit IS_FIRST = 1'b0
) (
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic [5:0]  bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_wr32_i,
  input wire logic        bus_rd_i,
  input wire logic [31:0] bus_rdata_o,
  input wire logic        protected_write_unlock_i,
  input wire logic        chain_sync_out_o,
  input wire logic        capture_sync_in_o,
  input wire logic        conv_start_a_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  property p_rsv6;
    bus_rd_i && bus_addr_i == 6'h06 |=> bus_rdata_o[15:0] == 16'h0000;
  endproperty
  a_rsv6: assert property (p_rsv6) else $error("word 6 read nonzero");
  property p_rsv13;
    bus_rd_i && bus_addr_i == 6'h13 |=> bus_rdata_o[15:0] == 16'h0000;
  endproperty
  a_rsv13: assert property (p_rsv13) else $error("word 13 read nonzero");
  property p_fine;
    !HAS_FINE && bus_rd_i && bus_addr_i == 6'h08 |=> bus_rdata_o[15:0] == 16'h0000;
  endproperty
  a_fine: assert property (p_fine) else $error("absent fine word read nonzero");
  property p_cap;
    capture_sync_in_o == (IS_FIRST & chain_sync_out_o);
  endproperty
  a_cap: assert property (p_cap) else $error("capture sync differs");
  property p_hold;
    !bus_rd_i |=> $stable(bus_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_prd;
    bus_wr_i && !bus_wr32_i && bus_addr_i == 6'h05 ##2 bus_rd_i && bus_addr_i == 6'h05
      |=> bus_rdata_o[15:0] == $past(bus_wdata_i[15:0], 3);
  endproperty
  a_prd: assert property (p_prd) else $error("period readback wrong");
  property p_w32;
    bus_wr_i && bus_wr32_i && bus_addr_i == 6'h10 ##2 bus_rd_i && bus_addr_i == 6'h10
      |=> bus_rdata_o == $past(bus_wdata_i, 3);
  endproperty
  a_w32: assert property (p_w32) else $error("wide write readback wrong");
  sequence s_lockwr;
    bus_wr_i && !bus_wr32_i && !protected_write_unlock_i && bus_addr_i == 6'h14;
  endsequence
  property p_lock;
    bus_rd_i && bus_addr_i == 6'h14 ##1 s_lockwr ##1 bus_rd_i && bus_addr_i == 6'h14
      |=> bus_rdata_o[15:0] == $past(bus_rdata_o[15:0], 2);
  endproperty
  a_lock: assert property (p_lock) else $error("locked write took effect");
  c_w32: cover property (bus_wr_i && bus_wr32_i);
  c_lock: cover property (s_lockwr);
  c_soc: cover property (conv_start_a_o);
endmodule : pcr_regs_chk
bind pcr_regs pcr_regs_chk #(.HAS_FINE(HAS_FINE), .IS_FIRST(IS_FIRST)) u_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_wr32_i(bus_wr32_i),
  .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
  .protected_write_unlock_i(protected_write_unlock_i), .chain_sync_out_o(chain_sync_out_o),
  .capture_sync_in_o(capture_sync_in_o), .conv_start_a_o(conv_start_a_o));
`default_nettype wire

// ==== verif/pcr_regs_tb_top.sv ====
/*
  Self-checking testbench for pcr_regs with the CPU model on its bus.
  Assumes no fine-resolution extension and a first-channel instance.
*/
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_tb_top;
  logic        mclk_i;
  logic        reset_n_i;
  logic [5:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        wr32;
  logic        rd;
  logic        unlock;
  logic [5:0]  fault_in;
  logic        sync_in;
  logic        sync_out;
  logic        cap_sync;
  logic        soc_a;
  logic        soc_b;
  logic        pwm_a;
  logic        pwm_b;
  int          n_mismatch;
  int          comparisons;
  pcr_cpu cpu (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
    .wr32_o(wr32), .rd_o(rd), .unlock_o(unlock));
  pcr_regs #(.HAS_FINE(1'b0), .IS_FIRST(1'b1)) DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_wr32_i(wr32),
    .bus_rd_i(rd), .bus_rdata_o(rdata), .protected_write_unlock_i(unlock),
    .fault_in_i(fault_in), .chain_sync_in_i(sync_in), .chain_sync_out_o(sync_out),
    .capture_sync_in_o(cap_sync), .pwm_out_a_o(pwm_a), .pwm_out_b_o(pwm_b),
    .conv_start_a_o(soc_a), .conv_start_b_o(soc_b));
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  // Samples, then idles the bus, for six cycles
  task automatic pulses(input int sel, output logic [31:0] n);
    n = 32'h0000_0000;
    repeat (6) begin
      sync_in = 1'b0;
      n = n + ((sel == 0) ? 32'(sync_out & cap_sync) : (sel == 1) ? 32'(soc_a) : 32'(soc_b));
      cpu.idle();
    end
  endtask : pulses
  task automatic t_shadow();
    logic [5:0]  offs[7] = '{6'h05, 6'h09, 6'h0a, 6'h0e, 6'h00, 6'h03, 6'h0f};
    logic [31:0] d;
    foreach (offs[i]) begin
      cpu.wr(offs[i], 1'b0, {26'h0000000, offs[i]} ^ 32'h0000_5a3c);
      cpu.rd(offs[i], d);
      cmp("rw word", {26'h0000000, offs[i]} ^ 32'h0000_5a3c, {16'h0000, d[15:0]});
    end
  endtask : t_shadow
  task automatic t_rsv();
    logic [5:0]  offs[6] = '{6'h06, 6'h13, 6'h1f, 6'h02, 6'h08, 6'h20};
    logic [31:0] d;
    cpu.lock(1'b1);
    foreach (offs[i]) begin
      cpu.wr(offs[i], 1'b0, 32'h0000_ffff);
      cpu.rd(offs[i], d);
      cmp("reserved word", 32'h0000_0000, {16'h0000, d[15:0]});
    end
  endtask : t_rsv
  task automatic t_wide();
    logic [31:0] d;
    cpu.wr(6'h10, 1'b1, 32'h1357_2468);
    cpu.rd(6'h10, d);
    cmp("wide pair", 32'h1357_2468, d);
    cpu.wr(6'h11, 1'b1, 32'hffff_ffff);
    cpu.rd(6'h10, d);
    cmp("odd wide write", 32'h1357_2468, d);
  endtask : t_wide
  task automatic t_lock();
    logic [31:0] d;
    cpu.lock(1'b0);
    cpu.cyc(1'b0, 1'b0, 1'b1, 6'h14, 32'h0000_0000);
    cpu.cyc(1'b1, 1'b0, 1'b0, 6'h14, 32'h0000_0005);
    cpu.rd(6'h14, d);
    cmp("locked write", 32'h0000_0000, {16'h0000, d[15:0]});
    cpu.lock(1'b1);
    cpu.wr(6'h14, 1'b0, 32'h0000_0005);
    cpu.rd(6'h14, d);
    cmp("unlocked write", 32'h0000_0005, {16'h0000, d[15:0]});
  endtask : t_lock
  task automatic t_fault();
    logic [31:0] d;
    cpu.wr(6'h12, 1'b0, 32'h0000_0004);
    cpu.wr(6'h17, 1'b0, 32'h0000_0001);
    fault_in = 6'h01;
    cpu.idle();
    cpu.rd(6'h16, d);
    cmp("ignored fault", 32'h0000_0000, {31'h00000000, d[0]});
    fault_in = 6'h04;
    cpu.idle();
    cpu.rd(6'h16, d);
    cmp("used fault", 32'h0000_0001, {31'h00000000, d[0]});
    cmp("trip outputs", 32'h0000_0003, {30'h00000000, pwm_b, pwm_a});
    fault_in = 6'h00;
  endtask : t_fault
  task automatic t_sync();
    logic [31:0] n;
    logic [31:0] d;
    cpu.wr(6'h00, 1'b0, 32'h0000_0000);
    sync_in = 1'b1;
    cpu.idle();
    pulses(0, n);
    cmp("sync passed", 32'h0000_0001, n);
    cpu.rd(6'h01, d);
    cmp("sync seen", 32'h0000_0002, {16'h0000, d[15:0]});
    cpu.wr(6'h01, 1'b0, 32'h0000_0002);
    cpu.rd(6'h01, d);
    cmp("sync seen cleared", 32'h0000_0000, {16'h0000, d[15:0]});
    cpu.wr(6'h00, 1'b0, 32'h0000_0030);
    sync_in = 1'b1;
    cpu.idle();
    pulses(0, n);
    cmp("sync silent", 32'h0000_0000, n);
  endtask : t_sync
  // Sync input loads the phase into the counter only when enabled
  task automatic t_phase();
    logic [31:0] d;
    cpu.wr(6'h03, 1'b0, 32'h0000_0100);
    cpu.wr(6'h00, 1'b0, 32'h0000_0030);
    cpu.wr(6'h04, 1'b0, 32'h0000_0000);
    sync_in = 1'b1;
    cpu.idle();
    sync_in = 1'b0;
    cpu.rd(6'h04, d);
    cmp("sync ignored", 32'h0000_0002, {16'h0000, d[15:0]});
    cpu.wr(6'h00, 1'b0, 32'h0000_0034);
    sync_in = 1'b1;
    cpu.idle();
    sync_in = 1'b0;
    cpu.rd(6'h04, d);
    cmp("sync used", 32'h0000_0100, {16'h0000, d[15:0]});
  endtask : t_phase
  task automatic t_soc();
    logic [31:0] n;
    logic [31:0] d;
    cpu.wr(6'h19, 1'b0, 32'h0000_8800);
    cpu.cyc(1'b1, 1'b0, 1'b0, 6'h1d, 32'h0000_0004);
    pulses(1, n);
    cmp("start a", 32'h0000_0001, n);
    cpu.cyc(1'b1, 1'b0, 1'b0, 6'h1d, 32'h0000_0008);
    pulses(2, n);
    cmp("start b", 32'h0000_0001, n);
    cpu.wr(6'h19, 1'b0, 32'h0000_0900);
    cpu.wr(6'h04, 1'b0, 32'h0000_0000);
    pulses(1, n);
    cmp("start a on zero", 32'h0000_0001, n);
    cpu.rd(6'h1b, d);
    cmp("start flags", 32'h0000_000c, {28'h0000000, d[3:2], 2'h0});
  endtask : t_soc
  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    #150000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    reset_n_i = 1'b0;
    fault_in = 6'h00;
    sync_in = 1'b0;
    repeat (6) @(negedge mclk_i);
    reset_n_i = 1'b1;
    t_shadow();
    t_rsv();
    t_wide();
    t_lock();
    t_fault();
    t_sync();
    t_phase();
    t_soc();
    give_verdict();
  end
endmodule : pcr_regs_tb_top
`default_nettype wire
